// ---- design/bsx_exec.sv ----
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - skip next when register bit matches value
// - skip next when io bit matches value
// - indexed flag branch, pc gets pc+k+1
// - signed ge taken when n xor v zero
// - signed lt taken when n xor v one
// - branches on interrupt enable, flags untouched
// - unsigned ge/lt branch on carry clear/set
// - branches on half carry, negative, zero
// - branches on transfer flag set or clear
// - branches on overflow flag, flags untouched
// - io bit write two cycles, others kept
// - left shift, zero in, updates z c n v
// - right shifts, logical zero fill, arithmetic keeps msb
// - rotates move carry in and out
// - register bit copied into transfer flag
// - transfer flag copied into register bit
module bsx_exec (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  instr_valid_i,
  input  wire logic [4:0]            instr_op_i,
  input  wire logic [2:0]            bit_sel_i,
  input  wire logic [6:0]            rel_ofs_i,
  input  wire logic                  next_two_word_i,
  input  wire logic [7:0]            reg_data_i,
  input  wire logic [4:0]            io_addr_i,
  input  wire logic [7:0]            io_data_i,
  output logic                       instr_ready_o,
  output logic                       instr_done_o,
  output logic      [15:0]           pc_o,
  output logic      [7:0]            flags_o,
  output logic                       reg_we_o,
  output logic      [7:0]            reg_wdata_o,
  output logic                       io_we_o,
  output logic      [4:0]            io_waddr_o,
  output logic      [7:0]            io_wdata_o
);

  bsx_pkg::bsx_state_t state_q;
  bsx_pkg::bsx_state_t state_d;
  bsx_pkg::bsx_op_t    op;
  logic [1:0]          cnt_q;
  logic [1:0]          cyc;
  logic [15:0]         pc_q;
  logic [15:0]         pc_d;
  logic [7:0]          flags_q;
  logic [7:0]          flags_d;
  logic [7:0]          res;
  logic                res_we;
  logic                io_we;
  logic [7:0]          io_val;
  logic                taken;
  logic                taken_q;
  logic                enable_q;
  logic                done_q;
  logic                reg_we_q;
  logic [7:0]          reg_wdata_q;
  logic                io_we_q;
  logic [4:0]          io_waddr_q;
  logic [7:0]          io_wdata_q;
  logic [15:0]         count_q;
  logic                accept;
  logic                apb_wr;
  logic                hit;
  logic [8:0]          sh;

  assign op            = bsx_pkg::bsx_op_t'(instr_op_i);
  assign instr_ready_o = (state_q == bsx_pkg::ST_IDLE) && enable_q;
  assign accept        = instr_valid_i && instr_ready_o;

  // relative target: offset is signed, counted from the next word
  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [6:0]  k);
    logic [15:0] ext;
    ext = {{9{k[6]}}, k};
    rel_target = pc + ext + bsx_pkg::PC_STEP;
  endfunction

  // skip length follows the size of the instruction being skipped
  function automatic logic [15:0] skip_step(input logic two_word);
    skip_step = two_word ? bsx_pkg::PC_SKIP2 : bsx_pkg::PC_SKIP1;
  endfunction

  // z c n v from a result and the carry out; v is n xor c
  function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                             input logic [7:0] r,
                                             input logic       c);
    logic [7:0] o;
    o = f;
    o[bsx_pkg::FLG_Z] = (r == 8'h00);
    o[bsx_pkg::FLG_C] = c;
    o[bsx_pkg::FLG_N] = r[7];
    o[bsx_pkg::FLG_V] = r[7] ^ c;
    shift_flags = o;
  endfunction

  // {carry out, result} for the five shift kinds
  function automatic logic [8:0] shift_calc(input bsx_pkg::bsx_op_t o,
                                            input logic [7:0]       d,
                                            input logic             c);
    case (o)
      bsx_pkg::OP_SHIFT_LEFT_LOGICAL:  shift_calc = {d[7], d[6:0], 1'b0};
      bsx_pkg::OP_SHIFT_RIGHT_LOGICAL: shift_calc = {d[0], 1'b0, d[7:1]};
      bsx_pkg::OP_SHIFT_RIGHT_ARITH:   shift_calc = {d[0], d[7], d[7:1]};
      bsx_pkg::OP_ROTATE_LEFT_CARRY:   shift_calc = {d[7], d[6:0], c};
      bsx_pkg::OP_ROTATE_RIGHT_CARRY:  shift_calc = {d[0], c, d[7:1]};
      default:                         shift_calc = {c, d};
    endcase
  endfunction

  assign sh = shift_calc(op, reg_data_i, flags_q[bsx_pkg::FLG_C]);

  always_comb begin
    pc_d    = pc_q + bsx_pkg::PC_STEP;
    flags_d = flags_q;
    res     = reg_data_i;
    res_we  = 1'b0;
    io_we   = 1'b0;
    io_val  = io_data_i;
    cyc     = bsx_pkg::CYC_ONE;
    taken   = 1'b0;
    case (op)
      bsx_pkg::OP_SKIP_IF_REG_BIT_ZERO,
      bsx_pkg::OP_SKIP_IF_REG_BIT_ONE: begin
        taken = reg_data_i[bit_sel_i] ==
                (op == bsx_pkg::OP_SKIP_IF_REG_BIT_ONE);
      end
      bsx_pkg::OP_SKIP_IF_IO_BIT_ZERO,
      bsx_pkg::OP_SKIP_IF_IO_BIT_ONE: begin
        taken = io_data_i[bit_sel_i] ==
                (op == bsx_pkg::OP_SKIP_IF_IO_BIT_ONE);
      end
      bsx_pkg::OP_BRANCH_ON_FLAG_ONE,
      bsx_pkg::OP_BRANCH_ON_FLAG_ZERO: begin
        taken = flags_q[bit_sel_i] ==
                (op == bsx_pkg::OP_BRANCH_ON_FLAG_ONE);
      end
      bsx_pkg::OP_BRANCH_SIGNED_GE: begin
        taken = (flags_q[bsx_pkg::FLG_N] ^ flags_q[bsx_pkg::FLG_V]) == 1'b0;
      end
      bsx_pkg::OP_BRANCH_SIGNED_LT: begin
        taken = (flags_q[bsx_pkg::FLG_N] ^ flags_q[bsx_pkg::FLG_V]) == 1'b1;
      end
      bsx_pkg::OP_IO_BIT_WRITE_ONE,
      bsx_pkg::OP_IO_BIT_WRITE_ZERO: begin
        io_we             = 1'b1;
        io_val[bit_sel_i] = (op == bsx_pkg::OP_IO_BIT_WRITE_ONE);
        cyc               = bsx_pkg::CYC_TWO;
      end
      bsx_pkg::OP_SHIFT_LEFT_LOGICAL,
      bsx_pkg::OP_SHIFT_RIGHT_LOGICAL,
      bsx_pkg::OP_SHIFT_RIGHT_ARITH,
      bsx_pkg::OP_ROTATE_LEFT_CARRY,
      bsx_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res     = sh[7:0];
        res_we  = 1'b1;
        flags_d = shift_flags(flags_q, sh[7:0], sh[8]);
      end
      bsx_pkg::OP_SWAP_NIBBLES: begin
        res    = {reg_data_i[3:0], reg_data_i[7:4]};
        res_we = 1'b1;
      end
      bsx_pkg::OP_INDEXED_FLAG_ONE,
      bsx_pkg::OP_INDEXED_FLAG_ZERO: begin
        flags_d[bit_sel_i] = (op == bsx_pkg::OP_INDEXED_FLAG_ONE);
      end
      bsx_pkg::OP_REG_BIT_TO_TRANSFER: begin
        flags_d[bsx_pkg::FLG_T] = reg_data_i[bit_sel_i];
      end
      bsx_pkg::OP_TRANSFER_TO_REG_BIT: begin
        res[bit_sel_i] = flags_q[bsx_pkg::FLG_T];
        res_we         = 1'b1;
      end
      default: begin
        cyc = bsx_pkg::CYC_ONE;
      end
    endcase
    case (op)
      bsx_pkg::OP_SKIP_IF_REG_BIT_ZERO,
      bsx_pkg::OP_SKIP_IF_REG_BIT_ONE,
      bsx_pkg::OP_SKIP_IF_IO_BIT_ZERO,
      bsx_pkg::OP_SKIP_IF_IO_BIT_ONE: begin
        // two or three words, cycles to match
        if (taken) begin
          pc_d = pc_q + skip_step(next_two_word_i);
          cyc  = next_two_word_i ? bsx_pkg::CYC_THREE : bsx_pkg::CYC_TWO;
        end
      end
      bsx_pkg::OP_BRANCH_ON_FLAG_ONE,
      bsx_pkg::OP_BRANCH_ON_FLAG_ZERO,
      bsx_pkg::OP_BRANCH_SIGNED_GE,
      bsx_pkg::OP_BRANCH_SIGNED_LT: begin
        if (taken) begin
          pc_d = rel_target(pc_q, rel_ofs_i);
          cyc  = bsx_pkg::CYC_TWO;
        end
      end
      default: begin
        pc_d = pc_q + bsx_pkg::PC_STEP;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      bsx_pkg::ST_IDLE: begin
        if (accept && (cyc != bsx_pkg::CYC_ONE)) begin
          state_d = bsx_pkg::ST_WAIT;
        end
      end
      bsx_pkg::ST_WAIT: begin
        if (cnt_q == bsx_pkg::CYC_ONE) begin
          state_d = bsx_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = bsx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= bsx_pkg::ST_IDLE;
      cnt_q   <= bsx_pkg::CYC_ONE;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= 1'b0;
      if (accept) begin
        cnt_q  <= cyc - bsx_pkg::CYC_ONE;
        done_q <= (cyc == bsx_pkg::CYC_ONE);
      end else if (state_q == bsx_pkg::ST_WAIT) begin
        cnt_q  <= cnt_q - bsx_pkg::CYC_ONE;
        done_q <= (cnt_q == bsx_pkg::CYC_ONE);
      end
    end
  end

  assign apb_wr = psel_i && penable_i && pwrite_i;

  // execution wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pc_q    <= bsx_pkg::PC_RST;
      flags_q <= bsx_pkg::FLAGS_RST;
      taken_q <= 1'b0;
    end else if (accept) begin
      pc_q    <= pc_d;
      flags_q <= flags_d;
      taken_q <= taken;
    end else if (apb_wr && (paddr_i == bsx_pkg::ADDR_PC)) begin
      pc_q <= pwdata_i[15:0];
    end else if (apb_wr && (paddr_i == bsx_pkg::ADDR_FLAGS)) begin
      flags_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable_q <= bsx_pkg::CTRL_RST;
    end else if (apb_wr && (paddr_i == bsx_pkg::ADDR_CTRL)) begin
      enable_q <= pwdata_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_q <= 16'h0000;
    end else if (accept) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // result writes commit on the accepting edge, shown for one cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_we_q    <= 1'b0;
      reg_wdata_q <= 8'h00;
      io_we_q     <= 1'b0;
      io_waddr_q  <= 5'h00;
      io_wdata_q  <= 8'h00;
    end else begin
      reg_we_q <= accept && res_we;
      io_we_q  <= accept && io_we;
      if (accept) begin
        reg_wdata_q <= res;
        io_waddr_q  <= io_addr_i;
        io_wdata_q  <= io_val;
      end
    end
  end

  always_comb begin
    hit      = 1'b1;
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      bsx_pkg::ADDR_FLAGS: prdata_o = {24'h000000, flags_q};
      bsx_pkg::ADDR_PC:    prdata_o = {16'h0000, pc_q};
      bsx_pkg::ADDR_CTRL:  prdata_o = {31'h00000000, enable_q};
      bsx_pkg::ADDR_STAT:  prdata_o = {30'h00000000, taken_q,
                                       state_q == bsx_pkg::ST_WAIT};
      bsx_pkg::ADDR_COUNT: prdata_o = {16'h0000, count_q};
      default:             hit      = 1'b0;
    endcase
  end

  // no wait states; unmapped words answer with an error
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && !hit;
  assign instr_done_o = done_q;
  assign pc_o         = pc_q;
  assign flags_o      = flags_q;
  assign reg_we_o     = reg_we_q;
  assign reg_wdata_o  = reg_wdata_q;
  assign io_we_o      = io_we_q;
  assign io_waddr_o   = io_waddr_q;
  assign io_wdata_o   = io_wdata_q;

endmodule

// ---- design/bsx_pkg.sv ----
package bsx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 16;
  localparam int unsigned IO_AW  = 5;
  localparam int unsigned OFS_W  = 7;
  localparam int unsigned BIT_W  = 3;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;

  // status flag positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  typedef enum logic [4:0] {
    OP_NONE                 = 5'h00,
    OP_SKIP_IF_REG_BIT_ZERO = 5'h01,
    OP_SKIP_IF_REG_BIT_ONE  = 5'h02,
    OP_SKIP_IF_IO_BIT_ZERO  = 5'h03,
    OP_SKIP_IF_IO_BIT_ONE   = 5'h04,
    OP_BRANCH_ON_FLAG_ONE   = 5'h05,
    OP_BRANCH_ON_FLAG_ZERO  = 5'h06,
    OP_BRANCH_SIGNED_GE     = 5'h07,
    OP_BRANCH_SIGNED_LT     = 5'h08,
    OP_IO_BIT_WRITE_ONE     = 5'h09,
    OP_IO_BIT_WRITE_ZERO    = 5'h0A,
    OP_SHIFT_LEFT_LOGICAL   = 5'h0B,
    OP_SHIFT_RIGHT_LOGICAL  = 5'h0C,
    OP_ROTATE_LEFT_CARRY    = 5'h0D,
    OP_ROTATE_RIGHT_CARRY   = 5'h0E,
    OP_SHIFT_RIGHT_ARITH    = 5'h0F,
    OP_SWAP_NIBBLES         = 5'h10,
    OP_INDEXED_FLAG_ONE     = 5'h11,
    OP_INDEXED_FLAG_ZERO    = 5'h12,
    OP_REG_BIT_TO_TRANSFER  = 5'h13,
    OP_TRANSFER_TO_REG_BIT  = 5'h14
  } bsx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } bsx_state_t;

  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  localparam logic [15:0] PC_STEP  = 16'h0001;
  localparam logic [15:0] PC_SKIP1 = 16'h0002;
  localparam logic [15:0] PC_SKIP2 = 16'h0003;

  localparam logic [11:0] ADDR_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_PC    = 12'h004;
  localparam logic [11:0] ADDR_CTRL  = 12'h008;
  localparam logic [11:0] ADDR_STAT  = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;

  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic        CTRL_RST  = 1'b1;

endpackage

// ---- test/bsx_core_model.sv ----
`timescale 1ns/1ps
module bsx_core_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] io_addr_i,
  input  wire logic       io_we_i,
  input  wire logic [4:0] io_waddr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_data_o
);
  logic [7:0] io_mem_q [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      io_mem_q[i] = 8'(i * 37);
    end
  end
  // low io space answers at once, no wait states
  assign io_data_o = io_mem_q[io_addr_i];
  // whole byte lands; the block must keep untouched bits itself
  always @(posedge clk_i) begin
    if (io_we_i) begin
      io_mem_q[io_waddr_i] <= io_wdata_i;
    end
  end
endmodule

// ---- test/bsx_exec_asserts.sv ----
`timescale 1ns/1ps
module bsx_exec_asserts (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        instr_valid_i,
  input wire logic [4:0]  instr_op_i,
  input wire logic [2:0]  bit_sel_i,
  input wire logic [6:0]  rel_ofs_i,
  input wire logic        next_two_word_i,
  input wire logic [7:0]  reg_data_i,
  input wire logic [7:0]  io_data_i,
  input wire logic        instr_ready_o,
  input wire logic        instr_done_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0]  flags_o,
  input wire logic [7:0]  reg_wdata_o,
  input wire logic        io_we_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic        nv;
  logic [7:0]  rd_q;
  logic [7:0]  fl_q;
  logic [15:0] pc_q;
  logic [15:0] tgt_q;
  logic        rbit_q;
  assign nv = flags_o[2] ^ flags_o[3];
  // operands held so results can be tied to their cause
  always_ff @(posedge clk_i) begin
    rd_q <= reg_data_i;
    fl_q <= flags_o;
    pc_q <= pc_o;
    tgt_q <= pc_o + {{9{rel_ofs_i[6]}}, rel_ofs_i} + 16'h0001;
    rbit_q <= reg_data_i[bit_sel_i];
  end
  sequence s_acc(bsx_pkg::bsx_op_t op);
    instr_valid_i && instr_ready_o && instr_op_i == op;
  endsequence
  sequence s_two_cyc;
    !instr_done_o ##1 instr_done_o;
  endsequence
  AST_SKIP_THREE: assert property (
    s_acc(bsx_pkg::OP_SKIP_IF_REG_BIT_ONE) ##0
    (reg_data_i[bit_sel_i] && next_two_word_i) |=> pc_o == pc_q + 16'h0003
    ##0 !instr_done_o ##1 s_two_cyc) else $error("skip over two words");
  AST_IO_NOSKIP: assert property (
    s_acc(bsx_pkg::OP_SKIP_IF_IO_BIT_ZERO) ##0 io_data_i[bit_sel_i]
    |=> pc_o == pc_q + 16'h0001 && instr_done_o) else $error("io skip");
  AST_GE_TAKEN: assert property (
    s_acc(bsx_pkg::OP_BRANCH_SIGNED_GE) ##0 !nv
    |=> pc_o == tgt_q ##0 s_two_cyc) else $error("signed ge branch");
  AST_LT_FALL: assert property (
    s_acc(bsx_pkg::OP_BRANCH_SIGNED_LT) ##0 !nv
    |=> pc_o == pc_q + 16'h0001 && instr_done_o) else $error("signed lt");
  AST_FLAG_TAKEN: assert property (
    s_acc(bsx_pkg::OP_BRANCH_ON_FLAG_ONE) ##0 flags_o[bit_sel_i]
    |=> pc_o == tgt_q ##0 s_two_cyc) else $error("flag branch");
  AST_BR_FLAGS: assert property (
    s_acc(bsx_pkg::OP_BRANCH_ON_FLAG_ONE) or
    s_acc(bsx_pkg::OP_BRANCH_ON_FLAG_ZERO) |=> $stable(flags_o))
    else $error("branch changed flags");
  AST_IO_WRITE: assert property (
    io_we_o |-> !instr_done_o ##1 (instr_done_o && !io_we_o))
    else $error("io bit write length");
  AST_SHL_ZERO_IN: assert property (
    s_acc(bsx_pkg::OP_SHIFT_LEFT_LOGICAL) |=>
    reg_wdata_o == {rd_q[6:0], 1'b0} && flags_o[0] == rd_q[7])
    else $error("left shift");
  AST_SHR_ARITH: assert property (
    s_acc(bsx_pkg::OP_SHIFT_RIGHT_ARITH) |=>
    reg_wdata_o == {rd_q[7], rd_q[7:1]}) else $error("arith shift");
  AST_ROT_RIGHT: assert property (
    s_acc(bsx_pkg::OP_ROTATE_RIGHT_CARRY) |=>
    reg_wdata_o == {fl_q[0], rd_q[7:1]} && flags_o[0] == rd_q[0])
    else $error("rotate right");
  AST_BIT_TO_T: assert property (
    s_acc(bsx_pkg::OP_REG_BIT_TO_TRANSFER) |=> flags_o[6] == rbit_q &&
    {flags_o[7], flags_o[5:0]} == {fl_q[7], fl_q[5:0]})
    else $error("bit store");
  AST_SWAP: assert property (
    s_acc(bsx_pkg::OP_SWAP_NIBBLES) |=>
    reg_wdata_o == {rd_q[3:0], rd_q[7:4]} && $stable(flags_o))
    else $error("nibble swap");
endmodule
bind bsx_exec bsx_exec_asserts bsx_exec_asserts_inst (
  .clk_i, .reset_n_i, .instr_valid_i, .instr_op_i, .bit_sel_i, .rel_ofs_i,
  .next_two_word_i, .reg_data_i, .io_data_i, .instr_ready_o, .instr_done_o,
  .pc_o, .flags_o, .reg_wdata_o, .io_we_o);

// ---- test/tb_branch_skip_bitop_exec.sv ----
`timescale 1ns/1ps
module tb_branch_skip_bitop_exec;
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, err, e_rwe;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, instr_valid_i, next_two_word_i, e_iwe;
  logic [4:0]  instr_op_i, io_addr_i, io_waddr_o;
  logic [2:0]  bit_sel_i;
  logic [6:0]  rel_ofs_i;
  logic [7:0]  reg_data_i, io_data_i, flags_o, reg_wdata_o, io_wdata_o;
  logic        instr_ready_o, instr_done_o, reg_we_o, io_we_o;
  logic [15:0] pc_o, e_pc;
  logic [7:0]  e_flg, e_res, e_io;
  logic        e_tk;
  int          num_errors, samples_checked, e_cyc, cyc, n_acc;
  int          tick = 0;
  bsx_exec bsx_exec_inst (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .instr_valid_i,
    .instr_op_i, .bit_sel_i, .rel_ofs_i, .next_two_word_i, .reg_data_i,
    .io_addr_i, .io_data_i, .instr_ready_o, .instr_done_o, .pc_o, .flags_o,
    .reg_we_o, .reg_wdata_o, .io_we_o, .io_waddr_o, .io_wdata_o);
  bsx_core_model bsx_core_model_inst (.clk_i, .io_addr_i, .io_we_i(io_we_o),
    .io_waddr_i(io_waddr_o), .io_wdata_i(io_wdata_o), .io_data_o(io_data_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hung handshake ends the run
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic void predict(input logic [4:0] op, input logic [2:0] b,
      input logic [6:0] k, input logic tw, input logic [7:0] r, io);
    logic t;
    t = 1'b0;
    e_res = r;
    e_io = io;
    e_cyc = 1;
    e_rwe = op inside {[5'h0B:5'h10], 5'h14};
    e_iwe = op inside {5'h09, 5'h0A};
    case (op)
      5'h01: t = ~r[b];
      5'h02: t = r[b];
      5'h03: t = ~io[b];
      5'h04: t = io[b];
      5'h05: t = e_flg[b];
      5'h06: t = ~e_flg[b];
      5'h07: t = ~(e_flg[2] ^ e_flg[3]);
      5'h08: t = e_flg[2] ^ e_flg[3];
      5'h09: e_io[b] = 1'b1;
      5'h0A: e_io[b] = 1'b0;
      5'h0B: {e_flg[0], e_res} = {r, 1'b0};
      5'h0C: {e_res, e_flg[0]} = {1'b0, r};
      5'h0D: {e_flg[0], e_res} = {r, e_flg[0]};
      5'h0E: {e_res, e_flg[0]} = {e_flg[0], r};
      5'h0F: {e_res, e_flg[0]} = {r[7], r};
      5'h10: e_res = {r[3:0], r[7:4]};
      5'h11: e_flg[b] = 1'b1;
      5'h12: e_flg[b] = 1'b0;
      5'h13: e_flg[6] = r[b];
      5'h14: e_res[b] = e_flg[6];
      default: ;
    endcase
    if (op inside {[5'h0B:5'h0F]}) begin
      e_flg[1] = (e_res == 8'h00);
      e_flg[2] = e_res[7];
      e_flg[3] = e_flg[2] ^ e_flg[0];
    end
    if (e_iwe) e_cyc = 2;
    e_tk = t;
    if (t && op < 5'h05) begin
      e_cyc = tw ? 3 : 2;
      e_pc = e_pc + (tw ? 16'h0003 : 16'h0002);
    end else if (t) begin
      e_cyc = 2;
      e_pc = e_pc + {{9{k[6]}}, k} + 16'h0001;
    end else begin
      e_pc = e_pc + 16'h0001;
    end
  endfunction
  task automatic run(input logic [4:0] op, input logic [2:0] b,
      input logic [6:0] k, input logic tw, input logic [7:0] r,
      input logic [4:0] ia);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    bit_sel_i <= b;
    rel_ofs_i <= k;
    next_two_word_i <= tw;
    reg_data_i <= r;
    io_addr_i <= ia;
    @(negedge clk_i);
    chk("ready", 16'h1, 16'(instr_ready_o));
    predict(op, b, k, tw, r, io_data_i);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    n_acc++;
    cyc = 0;
    do begin
      @(negedge clk_i);
      cyc++;
      if (cyc == 1) chk("reg_we", 16'(e_rwe), 16'(reg_we_o));
      if (cyc == 1) chk("io_we", 16'(e_iwe), 16'(io_we_o));
    end while (instr_done_o !== 1'b1 && cyc < 4);
    chk("cycles", 16'(e_cyc), 16'(cyc));
    chk("pc", e_pc, pc_o);
    chk("flags", 16'(e_flg), 16'(flags_o));
    if (e_rwe) chk("reg_wdata", 16'(e_res), 16'(reg_wdata_o));
    if (e_iwe) chk("io_wdata", 16'(e_io), 16'(io_wdata_o));
    if (e_iwe) chk("io_waddr", 16'(ia), 16'(io_waddr_o));
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, instr_valid_i, next_two_word_i} = '0;
    {paddr_i, pwdata_i, instr_op_i, bit_sel_i, rel_ofs_i} = '0;
    {reg_data_i, io_addr_i, reset_n_i} = '0;
    num_errors = 0;
    samples_checked = 0;
    e_pc = 16'h0000;
    e_flg = 8'h00;
    n_acc = 0;
    e_tk = 1'b0;
    void'($urandom(7));
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    chk("pc_reset", 16'h0, pc_o);
    chk("flags_reset", 16'h0, 16'(flags_o));
    apb(1'b0, 12'h008, 32'h0);
    chk("ctrl_reset", 16'h1, rd[15:0]);
    chk("mapped_err", 16'h0, 16'(err));
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 16'h1, 16'(err));
    apb(1'b1, 12'h008, 32'h0);
    @(negedge clk_i);
    chk("ready_disabled", 16'h0, 16'(instr_ready_o));
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h004, 32'hFFFF);
    e_pc = 16'hFFFF;
    apb(1'b1, 12'h000, 32'h8);
    e_flg = 8'h08;
    run(5'h08, 3'h0, 7'h40, 1'b0, 8'h00, 5'h00);
    run(5'h07, 3'h0, 7'h3F, 1'b0, 8'h00, 5'h00);
    run(5'h02, 3'h7, 7'h00, 1'b1, 8'h80, 5'h00);
    // undecoded op code must act as a one-cycle no-op
    run(5'h1F, 3'h0, 7'h00, 1'b0, 8'h00, 5'h00);
    for (int i = 0; i < 300; i++) begin
      if (i % 16 == 0) begin
        e_flg = 8'($urandom);
        apb(1'b1, 12'h000, {24'h0, e_flg});
        apb(1'b0, 12'h000, 32'h0);
        chk("flags_rb", 16'(e_flg), rd[15:0]);
      end
      run(5'($urandom % 21), 3'($urandom), 7'($urandom), 1'($urandom),
          8'($urandom), 5'($urandom));
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("pc_rb", e_pc, rd[15:0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("stat", 16'({e_tk, 1'b0}), rd[15:0]);
    apb(1'b0, 12'h010, 32'h0);
    chk("count", 16'(n_acc), rd[15:0]);
    complete_run();
  end
endmodule
